// ===== hw/code_lookup_if.sv
`timescale 1ns/1ps
interface code_lookup_if;
    import ternary_pkg::*;

    logic [CW_W-1:0]           rx_cw;
    logic [BITS_PER_GROUP-1:0] dec_group;
    logic                      dec_valid;

    modport table_side (input rx_cw, output dec_group, output dec_valid);
    modport user_side  (output rx_cw, input dec_group, input dec_valid);
endinterface

// ===== hw/ternary_4b3t_line_codec.sv
`timescale 1ns/1ps
module ternary_4b3t_line_codec #(
    parameter int SYM_CYCLES = ternary_pkg::SYMBOL_CYCLES
) (
    // Clock and reset
    input  wire logic                                  clock,
    input  wire logic                                  nrst,
    // Transmit group source
    input  wire logic [ternary_pkg::BITS_PER_GROUP-1:0] tx_group,
    output logic                                       tx_take_r,
    // Transmit line symbols
    output logic [1:0]                                 tx_sym_r,
    output logic                                       tx_sym_strobe_r,
    // Receive line symbols
    input  wire logic [1:0]                            rx_sym,
    input  wire logic                                  rx_sym_strobe,
    input  wire logic                                  rx_align,
    input  wire logic                                  rx_frame_end,
    // Receive groups and frame status
    output logic [ternary_pkg::BITS_PER_GROUP-1:0]     rx_group_r,
    output logic                                       rx_group_valid_r,
    output logic                                       rx_violation_r,
    output logic                                       rx_frame_done_r,
    output logic                                       rx_frame_errored_r
);
    import ternary_pkg::*;

    localparam int CNT_W = $clog2(SYM_CYCLES);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SYM_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_PRE  = CNT_W'(SYM_CYCLES - 2);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    localparam logic [1:0] Z = SYM_ZERO;
    localparam logic [1:0] P = SYM_PLUS;
    localparam logic [1:0] M = SYM_MINUS;

    // The take decode must lead the sampling tick by one cycle
    generate
        if (SYM_CYCLES < 4) begin : g_bad_rate
            $error("SYM_CYCLES must be at least 4");
        end
    endgenerate

    // Alphabet stepping helpers
    function automatic alpha_t alpha_up(input alpha_t a);
        case (a)
            ALPHA_1: alpha_up = ALPHA_2;
            ALPHA_2: alpha_up = ALPHA_3;
            default: alpha_up = ALPHA_4;
        endcase
    endfunction

    function automatic alpha_t alpha_down(input alpha_t a);
        case (a)
            ALPHA_4: alpha_down = ALPHA_3;
            ALPHA_3: alpha_down = ALPHA_2;
            default: alpha_down = ALPHA_1;
        endcase
    endfunction

    // ---------------- Transmit side ----------------
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [1:0]       tx_idx_r, tx_idx_nxt;
    logic [CW_W-1:0]  tx_cw_r, tx_cw_nxt;
    alpha_t           alpha_r, alpha_nxt;
    logic [1:0]       tx_sym_nxt;
    logic             tx_sym_strobe_nxt;
    logic             tx_take_nxt;
    logic [CW_W-1:0]  enc_cw;
    alpha_t           enc_next;
    logic             tick;

    assign tick = (cnt_r == CNT_LAST);

    // Encoding table for the current alphabet
    always_comb begin
        enc_cw   = cw3(Z, Z, Z);
        enc_next = alpha_r;
        case (tx_group)
            // Balanced groups keep the alphabet
            4'h1: enc_cw = cw3(Z, M, P);
            4'h7: enc_cw = cw3(M, Z, P);
            4'h4: enc_cw = cw3(M, P, Z);
            4'h2: enc_cw = cw3(P, M, Z);
            4'hB: enc_cw = cw3(P, Z, M);
            4'hE: enc_cw = cw3(Z, P, M);
            4'h9, 4'h3, 4'hD, 4'h8: begin
                if (alpha_r == ALPHA_4) begin
                    enc_next = (tx_group == 4'h9) ? ALPHA_1 : ALPHA_2;
                    case (tx_group)
                        4'h9:    enc_cw = cw3(M, M, M);
                        4'h3:    enc_cw = cw3(M, M, Z);
                        4'hD:    enc_cw = cw3(M, Z, M);
                        default: enc_cw = cw3(Z, M, M);
                    endcase
                end else begin
                    enc_next = alpha_up(alpha_r);
                    case (tx_group)
                        4'h9:    enc_cw = cw3(P, M, P);
                        4'h3:    enc_cw = cw3(Z, Z, P);
                        4'hD:    enc_cw = cw3(Z, P, Z);
                        default: enc_cw = cw3(P, Z, Z);
                    endcase
                end
            end
            4'h6, 4'hA: begin
                // Next alphabet is 2 from alphabets 1 and 3, else 3
                enc_next = (alpha_r == ALPHA_1 || alpha_r == ALPHA_3) ? ALPHA_2
                                                                      : ALPHA_3;
                if (alpha_r == ALPHA_1 || alpha_r == ALPHA_2) begin
                    enc_cw = (tx_group == 4'h6) ? cw3(M, P, P) : cw3(P, P, M);
                end else begin
                    enc_cw = (tx_group == 4'h6) ? cw3(M, M, P) : cw3(P, M, M);
                end
            end
            4'hF, 4'h0: begin
                if (alpha_r == ALPHA_1) begin
                    enc_next = ALPHA_3;
                    enc_cw   = (tx_group == 4'hF) ? cw3(P, P, Z) : cw3(P, Z, P);
                end else begin
                    enc_next = alpha_down(alpha_r);
                    enc_cw   = (tx_group == 4'hF) ? cw3(Z, Z, M) : cw3(Z, M, Z);
                end
            end
            default: begin
                // Groups 0101 and 1100
                if (alpha_r == ALPHA_1) begin
                    enc_next = (tx_group == 4'h5) ? ALPHA_3 : ALPHA_4;
                    enc_cw   = (tx_group == 4'h5) ? cw3(Z, P, P) : cw3(P, P, P);
                end else begin
                    enc_next = alpha_down(alpha_r);
                    enc_cw   = (tx_group == 4'h5) ? cw3(M, Z, Z) : cw3(M, P, M);
                end
            end
        endcase
    end

    // Baud counter and symbol shifter; a new group is taken every third tick
    always_comb begin
        cnt_nxt           = tick ? CNT_ZERO : cnt_r + 1'b1;
        tx_idx_nxt        = tx_idx_r;
        tx_cw_nxt         = tx_cw_r;
        alpha_nxt         = alpha_r;
        tx_sym_nxt        = tx_sym_r;
        tx_sym_strobe_nxt = tick;
        // Decoded one cycle early so tx_take_r is high in the tick cycle that samples tx_group
        tx_take_nxt       = (cnt_r == CNT_PRE) && (tx_idx_r == SYM_IDX_LAST);
        if (tick) begin
            if (tx_idx_r == SYM_IDX_LAST) begin
                tx_cw_nxt  = enc_cw;
                alpha_nxt  = enc_next;
                tx_sym_nxt = enc_cw[CW_W-1 -: 2];
                tx_idx_nxt = SYM_IDX_FIRST;
            end else begin
                tx_cw_nxt  = {tx_cw_r[CW_W-3:0], Z};
                tx_sym_nxt = tx_cw_r[CW_W-3 -: 2];
                tx_idx_nxt = tx_idx_r + 2'h1;
            end
        end
    end

    // Transmit registers; the first group is taken at the first tick
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_r           <= CNT_ZERO;
            tx_idx_r        <= SYM_IDX_LAST;
            tx_cw_r         <= '0;
            alpha_r         <= ALPHA_RESET;
            tx_sym_r        <= SYM_ZERO;
            tx_sym_strobe_r <= 1'b0;
            tx_take_r       <= 1'b0;
        end else begin
            cnt_r           <= cnt_nxt;
            tx_idx_r        <= tx_idx_nxt;
            tx_cw_r         <= tx_cw_nxt;
            alpha_r         <= alpha_nxt;
            tx_sym_r        <= tx_sym_nxt;
            tx_sym_strobe_r <= tx_sym_strobe_nxt;
            tx_take_r       <= tx_take_nxt;
        end
    end

    // ---------------- Receive side ----------------
    code_lookup_if lk ();

    ternary_decode_table u_decode (
        .lk (lk.table_side)
    );

    logic [1:0]                rx_idx_r, rx_idx_nxt;
    logic [CW_W-3:0]           rx_hold_r, rx_hold_nxt;
    logic                      rx_block_done;
    logic                      frame_err_r, frame_err_nxt;
    logic [BITS_PER_GROUP-1:0] rx_group_nxt;
    logic                      rx_group_valid_nxt;
    logic                      rx_violation_nxt;
    logic                      rx_frame_done_nxt;
    logic                      rx_frame_errored_nxt;
    logic                      viol_now;

    // Align forces the strobed symbol to be the first of a block
    assign rx_block_done = rx_sym_strobe && !rx_align && (rx_idx_r == SYM_IDX_LAST);
    assign lk.rx_cw      = {rx_hold_r, rx_sym};
    assign viol_now      = rx_block_done && !lk.dec_valid;

    // Symbol gathering, decode and frame error accumulation
    always_comb begin
        rx_idx_nxt           = rx_idx_r;
        rx_hold_nxt          = rx_hold_r;
        rx_group_nxt         = rx_group_r;
        rx_group_valid_nxt   = rx_block_done;
        rx_violation_nxt     = viol_now;
        frame_err_nxt        = frame_err_r || viol_now;
        rx_frame_done_nxt    = rx_frame_end;
        rx_frame_errored_nxt = rx_frame_errored_r;
        if (rx_sym_strobe) begin
            if (rx_align || rx_idx_r == SYM_IDX_LAST) begin
                rx_hold_nxt = {rx_hold_r[1:0] & 2'h0, rx_sym};
                rx_idx_nxt  = rx_align ? 2'h1 : SYM_IDX_FIRST;
            end else begin
                rx_hold_nxt = {rx_hold_r[1:0], rx_sym};
                rx_idx_nxt  = rx_idx_r + 2'h1;
            end
        end
        if (rx_block_done) begin
            // Group held as last decoded; zero on a violation
            rx_group_nxt = lk.dec_valid ? lk.dec_group : 4'h0;
        end
        if (rx_frame_end) begin
            // A violation in the closing cycle still counts for this frame
            rx_frame_errored_nxt = frame_err_r || viol_now;
            frame_err_nxt        = 1'b0;
        end
    end

    // Receive registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rx_idx_r           <= SYM_IDX_FIRST;
            rx_hold_r          <= '0;
            frame_err_r        <= 1'b0;
            rx_group_r         <= '0;
            rx_group_valid_r   <= 1'b0;
            rx_violation_r     <= 1'b0;
            rx_frame_done_r    <= 1'b0;
            rx_frame_errored_r <= 1'b0;
        end else begin
            rx_idx_r           <= rx_idx_nxt;
            rx_hold_r          <= rx_hold_nxt;
            frame_err_r        <= frame_err_nxt;
            rx_group_r         <= rx_group_nxt;
            rx_group_valid_r   <= rx_group_valid_nxt;
            rx_violation_r     <= rx_violation_nxt;
            rx_frame_done_r    <= rx_frame_done_nxt;
            rx_frame_errored_r <= rx_frame_errored_nxt;
        end
    end

endmodule // ternary_4b3t_line_codec

// ===== hw/ternary_decode_table.sv
`timescale 1ns/1ps
module ternary_decode_table (
    code_lookup_if.table_side lk
);
    import ternary_pkg::*;

    localparam logic [1:0] Z = SYM_ZERO;
    localparam logic [1:0] P = SYM_PLUS;
    localparam logic [1:0] M = SYM_MINUS;

    // Inverse table; each codeword names one group in any alphabet
    always_comb begin
        lk.dec_valid = 1'b1;
        lk.dec_group = 4'h0;
        case (lk.rx_cw)
            cw3(Z, M, P): lk.dec_group = 4'h1;
            cw3(M, Z, P): lk.dec_group = 4'h7;
            cw3(M, P, Z): lk.dec_group = 4'h4;
            cw3(P, M, Z): lk.dec_group = 4'h2;
            cw3(P, Z, M): lk.dec_group = 4'hB;
            cw3(Z, P, M): lk.dec_group = 4'hE;
            cw3(P, M, P), cw3(M, M, M): lk.dec_group = 4'h9;
            cw3(Z, Z, P), cw3(M, M, Z): lk.dec_group = 4'h3;
            cw3(Z, P, Z), cw3(M, Z, M): lk.dec_group = 4'hD;
            cw3(P, Z, Z), cw3(Z, M, M): lk.dec_group = 4'h8;
            cw3(M, P, P), cw3(M, M, P): lk.dec_group = 4'h6;
            cw3(P, P, M), cw3(P, M, M): lk.dec_group = 4'hA;
            cw3(P, P, Z), cw3(Z, Z, M): lk.dec_group = 4'hF;
            cw3(P, Z, P), cw3(Z, M, Z): lk.dec_group = 4'h0;
            cw3(Z, P, P), cw3(M, Z, Z): lk.dec_group = 4'h5;
            cw3(P, P, P), cw3(M, P, M): lk.dec_group = 4'hC;
            cw3(Z, Z, Z): lk.dec_group = 4'h0;
            // Any block holding a non-level symbol is a violation
            default: lk.dec_valid = 1'b0;
        endcase
    end

endmodule // ternary_decode_table

// ===== hw/ternary_pkg.sv
package ternary_pkg;

    // Line symbol levels, two bits per ternary symbol
    localparam logic [1:0] SYM_ZERO    = 2'h0;
    localparam logic [1:0] SYM_PLUS    = 2'h1;
    localparam logic [1:0] SYM_BAD     = 2'h2;   // Not a level; always a code violation
    localparam logic [1:0] SYM_MINUS   = 2'h3;

    // Group and codeword shape
    localparam int         BITS_PER_GROUP = 4;
    localparam int         SYMS_PER_CW    = 3;
    localparam int         CW_W           = 2 * SYMS_PER_CW;
    localparam logic [1:0] SYM_IDX_FIRST  = 2'h0;
    localparam logic [1:0] SYM_IDX_LAST   = 2'h2;

    // Symbol timing: 120 kbaud from a 50 MHz clock, period rounded down
    localparam int CLOCK_HZ      = 50_000_000;
    localparam int SYMBOL_BAUD   = 120_000;
    localparam int SYMBOL_CYCLES = CLOCK_HZ / SYMBOL_BAUD;

    // Alphabet state of the encoder
    typedef enum logic [1:0] {
        ALPHA_1 = 2'b00,
        ALPHA_2 = 2'b01,
        ALPHA_3 = 2'b10,
        ALPHA_4 = 2'b11
    } alpha_t;

    localparam alpha_t ALPHA_RESET = ALPHA_1;

    // Build a codeword, first symbol in the top bits
    function automatic logic [CW_W-1:0] cw3(input logic [1:0] s0,
                                            input logic [1:0] s1,
                                            input logic [1:0] s2);
        cw3 = {s0, s1, s2};
    endfunction

endpackage

// ===== tb/remote_line_model.sv
`timescale 1ns/1ps
module remote_line_model (
    // Clock
    input  wire logic       clock,
    // Symbols toward the device
    output      logic [1:0] rx_sym,
    output      logic       rx_sym_strobe,
    output      logic       rx_align,
    output      logic       rx_frame_end
);
    // Idle line at time zero
    initial begin
        rx_sym = 2'h2;
        rx_sym_strobe = 1'b0;
        rx_align = 1'b0;
        rx_frame_end = 1'b0;
    end

    // One symbol per strobe; gap 0 keeps the strobe up for the next call
    task automatic send_sym(input logic [1:0] sym, input logic first, input int gap);
        rx_sym = sym;
        rx_sym_strobe = 1'b1;
        rx_align = first;
        @(posedge clock);
        #1;
        if (gap != 0) begin
            rx_sym_strobe = 1'b0;
            rx_align = 1'b0;
            rx_sym = ~sym; // Stale level differs from the sent one; only a plus turns into the illegal level
            repeat (gap) begin
                @(posedge clock);
                #1;
            end
        end
    endtask

    // Leftmost symbol first; the last one always idles the line after it
    task automatic send_block(input logic [5:0] c, input int gap);
        send_sym(c[5:4], 1'b1, gap);
        send_sym(c[3:2], 1'b0, gap);
        send_sym(c[1:0], 1'b0, gap + 1);
    endtask

    // Last symbol of a block in the very cycle that closes the frame
    task automatic close_on_sym(input logic [1:0] sym);
        rx_frame_end = 1'b1;
        send_sym(sym, 1'b0, 0);
        rx_frame_end = 1'b0;
        rx_sym_strobe = 1'b0;
        rx_sym = ~sym;
        @(posedge clock);
        #1;
    endtask

    // Frame boundary pulse with a quiet cycle after it
    task automatic end_frame();
        rx_frame_end = 1'b1;
        @(posedge clock);
        #1;
        rx_frame_end = 1'b0;
        @(posedge clock);
        #1;
    endtask
endmodule // remote_line_model

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
    import ternary_pkg::*;
    localparam int SYM_CYCLES = 4;
    // Per group: {class, positive word, negative word}
    localparam logic [13:0] TBL [16] = '{
        {2'h3, 6'h11, 6'h0C}, {2'h0, 6'h0D, 6'h0D}, {2'h0, 6'h1C, 6'h1C}, {2'h1, 6'h01, 6'h3C},
        {2'h0, 6'h34, 6'h34}, {2'h3, 6'h05, 6'h30}, {2'h2, 6'h35, 6'h3D}, {2'h0, 6'h31, 6'h31},
        {2'h1, 6'h10, 6'h0F}, {2'h1, 6'h1D, 6'h3F}, {2'h2, 6'h17, 6'h1F}, {2'h0, 6'h13, 6'h13},
        {2'h3, 6'h15, 6'h37}, {2'h1, 6'h04, 6'h33}, {2'h0, 6'h07, 6'h07}, {2'h3, 6'h14, 6'h03}};
    logic       clock, nrst, tx_take_r, tx_sym_strobe_r, rx_sym_strobe, rx_align, rx_frame_end;
    logic [3:0] tx_group, rx_group_r;
    logic [1:0] tx_sym_r, rx_sym, alpha;
    logic       rx_group_valid_r, rx_violation_r, rx_frame_done_r, rx_frame_errored_r;
    logic       take_seen, frame_bad;
    logic [7:0] e_tx;
    logic [4:0] e_rx;
    logic [1:0] e_sym;
    logic       e_fr;
    logic [5:0] cw;
    logic [1:0] tx_q[$];
    logic [4:0] rx_q[$];
    logic       fr_q[$];
    int         n_errors, total_checks, i;

    // Encoder reference, returns {next alphabet, codeword}
    function automatic logic [7:0] enc(input logic [1:0] a, input logic [3:0] g);
        logic [1:0] k, nx;
        logic       pos;
        k = TBL[g][13:12];
        case (k)
            2'h0: nx = a;
            2'h1: nx = (a == 2'h3) ? ((g == 4'h9) ? 2'h0 : 2'h1) : a + 2'h1;
            2'h2: nx = a[0] ? 2'h2 : 2'h1;
            default: nx = (a == 2'h0) ? ((g == 4'hC) ? 2'h3 : 2'h2) : a - 2'h1;
        endcase
        pos = (k == 2'h0) || (k == 2'h1 && a != 2'h3) || (k == 2'h2 && !a[1]) || a == 2'h0;
        return {nx, pos ? TBL[g][11:6] : TBL[g][5:0]};
    endfunction

    // Decoder reference, {violation, group}; no alphabet involved
    function automatic logic [4:0] dec(input logic [5:0] c);
        if (c[5:4] == SYM_BAD || c[3:2] == SYM_BAD || c[1:0] == SYM_BAD) return 5'h10;
        for (int g = 0; g < 16; g++)
            if (TBL[g][11:6] == c || TBL[g][5:0] == c) return {1'b0, 4'(g)};
        return 5'h00;
    endfunction

    function automatic logic [1:0] sym3(input int v);
        return (v == 0) ? SYM_ZERO : ((v == 1) ? SYM_PLUS : SYM_MINUS);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Note the decode first, then put the block on the line
    task automatic block(input logic [5:0] c, input int gap);
        rx_q.push_back(dec(c));
        frame_bad = frame_bad | 1'(dec(c) >> 4);
        peer.send_block(c, gap);
    endtask

    task automatic close_frame();
        fr_q.push_back(frame_bad);
        frame_bad = 1'b0;
        peer.end_frame();
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    ternary_4b3t_line_codec #(.SYM_CYCLES(SYM_CYCLES)) dut (
        .clock(clock), .nrst(nrst), .tx_group(tx_group), .tx_take_r(tx_take_r),
        .tx_sym_r(tx_sym_r), .tx_sym_strobe_r(tx_sym_strobe_r), .rx_sym(rx_sym),
        .rx_sym_strobe(rx_sym_strobe), .rx_align(rx_align), .rx_frame_end(rx_frame_end),
        .rx_group_r(rx_group_r), .rx_group_valid_r(rx_group_valid_r),
        .rx_violation_r(rx_violation_r), .rx_frame_done_r(rx_frame_done_r),
        .rx_frame_errored_r(rx_frame_errored_r));

    remote_line_model peer (.clock(clock), .rx_sym(rx_sym), .rx_sym_strobe(rx_sym_strobe),
        .rx_align(rx_align), .rx_frame_end(rx_frame_end));

    // Group source; a new random group only after the old one was taken
    always @(posedge clock) begin
        if (!nrst) begin
            alpha = 2'h0;
            take_seen = 1'b0;
            tx_q.delete();
        end
        #1;
        if (take_seen) tx_group = 4'($urandom);
        take_seen = tx_take_r;
        if (tx_take_r === 1'b1) begin
            e_tx = enc(alpha, tx_group);
            alpha = e_tx[7:6];
            tx_q.push_back(e_tx[5:4]);
            tx_q.push_back(e_tx[3:2]);
            tx_q.push_back(e_tx[1:0]);
        end
    end

    // Each result is matched to the oldest note
    always @(posedge clock) begin
        #1;
        if (tx_sym_strobe_r === 1'b1) begin
            // An empty queue expects the illegal level, so a surplus symbol always fails
            e_sym = tx_q.size() ? tx_q.pop_front() : SYM_BAD;
            check(8'(tx_sym_r), 8'(e_sym));
        end
        if (rx_group_valid_r === 1'b1) begin
            e_rx = rx_q.size() ? rx_q.pop_front() : 5'h1F;
            check(8'({rx_violation_r, rx_group_r}), 8'(e_rx));
        end
        if (rx_frame_done_r === 1'b1) begin
            e_fr = fr_q.size() ? fr_q.pop_front() : 1'bx;
            check(8'(rx_frame_errored_r), 8'(e_fr));
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        give_verdict();
    end

    initial begin
        void'($urandom(93202));
        nrst = 1'b0;
        tx_group = 4'h0;
        frame_bad = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (20) @(posedge clock);
        #1;
        nrst = 1'b1;
        // All 27 triples, back-to-back and spaced
        for (i = 0; i < 27; i++) begin
            cw = {sym3(i / 9), sym3((i / 3) % 3), sym3(i % 3)};
            block(cw, i % 3);
        end
        close_frame();
        // Random levels, a sure violation, then a block cut short by realignment
        for (i = 0; i < 12; i++) block(6'($urandom), 1);
        block(6'h21, 0);
        peer.send_sym(SYM_PLUS, 1'b1, 0);
        peer.send_sym(SYM_MINUS, 1'b0, 0);
        block(6'h35, 0);
        close_frame();
        // Violation decoded in the closing cycle errors the frame it closes, not the next
        rx_q.push_back(dec({SYM_ZERO, SYM_BAD, SYM_PLUS}));
        fr_q.push_back(1'b1);
        peer.send_sym(SYM_ZERO, 1'b1, 0);
        peer.send_sym(SYM_BAD, 1'b0, 0);
        peer.close_on_sym(SYM_PLUS);
        block(6'h00, 2);
        close_frame();
        repeat (3000) @(posedge clock);
        #1;
        // Reset in mid-run: encoder restarts from alphabet one
        nrst = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        nrst = 1'b1;
        repeat (600) @(posedge clock);
        check(8'(rx_q.size()), 8'h00);
        check(8'(fr_q.size()), 8'h00);
        give_verdict();
    end
endmodule // tb

bind ternary_4b3t_line_codec ternary_codec_props #(.SYM_CYCLES(SYM_CYCLES)) props (
    .clock(clock), .nrst(nrst), .tx_take_r(tx_take_r), .tx_sym_r(tx_sym_r),
    .tx_sym_strobe_r(tx_sym_strobe_r), .rx_sym_strobe(rx_sym_strobe), .rx_align(rx_align),
    .rx_frame_end(rx_frame_end), .rx_group_r(rx_group_r), .rx_group_valid_r(rx_group_valid_r),
    .rx_violation_r(rx_violation_r), .rx_frame_done_r(rx_frame_done_r),
    .rx_frame_errored_r(rx_frame_errored_r));

// ===== tb/ternary_codec_props.sv
`timescale 1ns/1ps
module ternary_codec_props #(
    parameter int SYM_CYCLES = 4
) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       nrst,
    // Transmit side
    input wire logic       tx_take_r,
    input wire logic [1:0] tx_sym_r,
    input wire logic       tx_sym_strobe_r,
    // Receive side
    input wire logic       rx_sym_strobe,
    input wire logic       rx_align,
    input wire logic       rx_frame_end,
    input wire logic [3:0] rx_group_r,
    input wire logic       rx_group_valid_r,
    input wire logic       rx_violation_r,
    input wire logic       rx_frame_done_r,
    input wire logic       rx_frame_errored_r
);
    import ternary_pkg::*;
    logic [15:0] tgap_r, sgap_r;
    logic [1:0]  nsym_r, rpos_r;
    logic        seen_r, third_r;

    // Counters since the last take and strobe; receive block position
    always_ff @(posedge clock) begin
        if (!nrst) begin
            tgap_r  <= 16'h0000;
            sgap_r  <= 16'h0000;
            nsym_r  <= 2'h0;
            rpos_r  <= 2'h0;
            seen_r  <= 1'b0;
            third_r <= 1'b0;
        end else begin
            tgap_r  <= tx_take_r ? 16'h0000 : tgap_r + 16'h0001;
            sgap_r  <= tx_sym_strobe_r ? 16'h0000 : sgap_r + 16'h0001;
            nsym_r  <= tx_take_r ? 2'h0 : nsym_r + {1'b0, tx_sym_strobe_r};
            seen_r  <= seen_r | tx_take_r;
            third_r <= rx_sym_strobe && !rx_align && rpos_r == 2'h2;
            if (rx_sym_strobe) begin
                rpos_r <= rx_align ? 2'h1 : ((rpos_r == 2'h2) ? 2'h0 : rpos_r + 2'h1);
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    AST_TAKE_PERIOD: assert property (
        tx_take_r && seen_r |-> tgap_r == 3 * SYM_CYCLES - 1)
        else $error("group take spacing wrong");
    AST_THREE_SYMS: assert property (tx_take_r && seen_r |-> nsym_r == 2'h3)
        else $error("codeword did not hold three symbols");
    AST_FIRST_SYM: assert property (tx_take_r |=> tx_sym_strobe_r)
        else $error("first symbol late after take");
    AST_SYM_SPACING: assert property (
        tx_sym_strobe_r && nsym_r != 2'h0 |-> sgap_r == SYM_CYCLES - 1)
        else $error("symbol spacing wrong");
    AST_SYM_HELD: assert property (!tx_sym_strobe_r |-> $stable(tx_sym_r))
        else $error("line level moved between symbols");
    AST_NO_BAD_LEVEL: assert property (tx_sym_r != SYM_BAD)
        else $error("illegal line level sent");
    AST_RX_ANSWER: assert property (rx_group_valid_r == third_r)
        else $error("decoded group at wrong time");
    AST_VIOL_ZERO: assert property (
        rx_violation_r |-> rx_group_valid_r && rx_group_r == 4'h0)
        else $error("violation without zero group");
    AST_FRAME_DONE: assert property (rx_frame_end |=> rx_frame_done_r)
        else $error("frame close not reported");
    AST_ERR_HELD: assert property (!rx_frame_done_r |-> $stable(rx_frame_errored_r))
        else $error("frame status moved outside frame close");
    // A violation decoded in the closing cycle must still error that frame
    AST_CLOSE_VIOL: assert property (
        rx_violation_r && rx_frame_done_r |-> rx_frame_errored_r)
        else $error("closing cycle violation lost");

    // Main scenarios reached
    cover property (tx_take_r && seen_r);
    cover property (rx_violation_r);
    cover property (rx_frame_done_r && rx_frame_errored_r);
    cover property (rx_violation_r && rx_frame_done_r);
endmodule // ternary_codec_props
